// ### hw/fault_status_consts.vh
// Register map, field positions and clear codes of the fault status bank.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef FAULT_STATUS_CONSTS_VH
`define FAULT_STATUS_CONSTS_VH

// Printed register indexes; byte address is four times the index
`define IDX_FAULT_SUMMARY      9'h080
`define IDX_CELL_OVER          9'h081
`define IDX_CELL_UNDER         9'h082
`define IDX_OPEN_WIRE          9'h083
`define IDX_GENERAL_FAULT      9'h085
`define IDX_OVERRIDE_CMD       9'h0f0
`define IDX_DETECT_STATUS      9'h0f1
`define IDX_IRQ_STATUS         9'h0f2
`define IDX_IRQ_MASK           9'h0f3

// Summary field positions
`define BIT_VSS_OPEN           9
`define BIT_CHECKSUM           10
`define BIT_REFERENCE          11
`define BIT_REGULATOR          12
`define BIT_TEMP_MUX           13
`define BIT_CELL_MUX           14
`define BIT_DIE_TEMP           15

// General fault field positions
`define BIT_NONVOL_PARITY      2
`define BIT_PAGE_ONE_PARITY    3

// Clear codes
`define CLR_VSS_OPEN           16'h0200
`define CLR_REFERENCE          16'h0800
`define CLR_REGULATOR          16'h1000
`define CLR_TEMP_MUX           16'h2000
`define CLR_CELL_MUX           16'h4000
`define CLR_DIE_TEMP           16'h8000
`define CLR_ALL                16'hffff
`define CLR_GENERAL            16'h000f

// Field masks and reset values
`define CELL_MASK              16'h3fff
`define OPEN_WIRE_MASK         16'h7fff
`define GENERAL_MASK           16'h000f
`define SUMMARY_WR_MASK        16'hfa00
`define FAULT_RESET            16'h0000

// Interrupt status bits
`define IRQ_SUMMARY            0
`define IRQ_OVER               1
`define IRQ_UNDER              2
`define IRQ_OPEN_WIRE          3
`define IRQ_GENERAL            4
`define IRQ_WIDTH              5

`endif

// ### hw/fault_status_registers.v
// Fault flag bank: summary, per-cell over/undervoltage, open-wire and general fault registers.
// Assumes detector inputs are synchronous to clk_sys_in and APB master from the same clock.
// Summary of operation
// - Ground-sense open wire sets vss_open_fault; write 0x200 or all ones clears it.
// - checksum_error is the OR of both parity flags; summary writes never touch it.
// - Reference out of range sets flag; 0x0800 or all ones clears; direct write sets.
// - Regulator out of power-good sets flag; 0x1000 or all ones clears; direct write sets.
// - Temperature mux self-test fault sets flag; 0x2000 or all ones clears it.
// - Cell mux self-test fault sets flag; 0x4000 or all ones clears it.
// - Die over warning threshold sets flag; 0x8000 or all ones clears it.
// - Overvoltage cells 14..1 sit in bits 13..0, upper bits reserved, reset zero.
// - Writing all ones to a per-cell register clears every flag whose detector is low.
// - Override command then write replaces the register contents with written data.
// - Overvoltage clear leaves totalizer alone, so next bad sample sets flag again.
// - Undervoltage register holds 14 cell flags in bits 13..0, reset zero.
// - Undervoltage clear leaves totalizer alone; flag sets again on next bad sample.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "fault_status_consts.vh"

// ---------------------------------------------------------------
// Register map (word index, byte address is four times the index)
// ---------------------------------------------------------------
// 0x080 fault summary: bits 9, 11..15 flags, bit 10 checksum, bits 8..0 read zero
// 0x081 cell overvoltage flags: bits 13..0
// 0x082 cell undervoltage flags: bits 13..0
// 0x083 open-wire flags: bits 14..0
// 0x085 general fault: bits 3..0, cleared by writing 0x000f
// 0x0f0 override command: bit 0 arms a direct overwrite of the next fault write
// 0x0f1 detect status: one bit per register that holds any set flag
// 0x0f2 interrupt status: write one to clear, set wins over clear
// 0x0f3 interrupt mask: same layout as the interrupt status
//
// Every access takes one wait state; pready is a one-cycle pulse.
// Unmapped addresses answer with pslverr and have no effect.

module fault_status_registers #(
  parameter CELLS = 14
) (
  input  wire        clk_sys_in,
  input  wire        arst_n_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  input  wire [3:0]  pstrb_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        vss_open_det_in,
  input  wire        reference_det_in,
  input  wire        regulator_det_in,
  input  wire        temp_mux_det_in,
  input  wire        cell_mux_det_in,
  input  wire        die_temp_det_in,
  input  wire [13:0] cell_over_det_in,
  input  wire [13:0] cell_under_det_in,
  input  wire [14:0] open_wire_det_in,
  input  wire [1:0]  general_det_in,
  input  wire        nonvol_parity_det_in,
  input  wire        page_one_parity_det_in,
  output reg         fault_active_out,
  output reg         irq_out
);

  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  reg rst_meta;
  reg rst_n;
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  function is_idx;
    input [11:0] addr;
    input [8:0]  idx;
    begin
      is_idx = (addr[1:0] == 2'b00) && (addr[11:2] == {1'b0, idx});
    end
  endfunction

  wire        access   = psel_in && penable_in && !pready_out;
  wire        wr       = access && pwrite_in && (pstrb_in[1:0] == 2'b11);
  wire [15:0] wdata    = pwdata_in[15:0];
  wire        wr_sum   = wr && is_idx(paddr_in, `IDX_FAULT_SUMMARY);
  wire        wr_over  = wr && is_idx(paddr_in, `IDX_CELL_OVER);
  wire        wr_under = wr && is_idx(paddr_in, `IDX_CELL_UNDER);
  wire        wr_open  = wr && is_idx(paddr_in, `IDX_OPEN_WIRE);
  wire        wr_gen   = wr && is_idx(paddr_in, `IDX_GENERAL_FAULT);
  wire        wr_ovr   = wr && is_idx(paddr_in, `IDX_OVERRIDE_CMD);
  wire        wr_ist   = wr && is_idx(paddr_in, `IDX_IRQ_STATUS);
  wire        wr_imsk  = wr && is_idx(paddr_in, `IDX_IRQ_MASK);
  wire        mapped   = is_idx(paddr_in, `IDX_FAULT_SUMMARY) || is_idx(paddr_in, `IDX_CELL_OVER) ||
                         is_idx(paddr_in, `IDX_CELL_UNDER) || is_idx(paddr_in, `IDX_OPEN_WIRE) ||
                         is_idx(paddr_in, `IDX_GENERAL_FAULT) || is_idx(paddr_in, `IDX_OVERRIDE_CMD) ||
                         is_idx(paddr_in, `IDX_DETECT_STATUS) || is_idx(paddr_in, `IDX_IRQ_STATUS) ||
                         is_idx(paddr_in, `IDX_IRQ_MASK);

  // ---------------------------------------------------------------
  // Override arming: one command arms the next fault-register write
  // ---------------------------------------------------------------
  // Writes to other registers leave the arming in place, so the
  // host may touch the interrupt registers between the two steps.
  reg  override_armed;
  wire fault_wr   = wr_sum || wr_over || wr_under || wr_open || wr_gen;
  wire direct_wr  = override_armed;
  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      override_armed <= 1'b0;
    end else if (wr_ovr) begin
      override_armed <= wdata[0];
    end else if (fault_wr) begin
      override_armed <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Write-clear helper: next value of a detector-set flag field
  // ---------------------------------------------------------------
  // A detector that is still high wins over a clear in the same
  // cycle; no totalizer filtering is modelled here.
  function [15:0] next_field;
    input [15:0] cur;
    input [15:0] det;
    input        we;
    input        direct;
    input [15:0] data;
    input [15:0] mask;
    reg   [15:0] base;
    begin
      base = cur;
      if (we && direct) begin
        base = data;
      end else if (we && (data == `CLR_ALL)) begin
        base = 16'h0000;
      end
      next_field = (base | det) & mask;
    end
  endfunction

  // ---------------------------------------------------------------
  // Per-cell, open-wire and general fault registers
  // ---------------------------------------------------------------
  reg [15:0] cell_overvoltage_flags;
  reg [15:0] cell_undervoltage_flags;
  reg [15:0] open_wire_flags;
  reg [15:0] general_fault;
  wire [15:0] gen_det = {12'h000, page_one_parity_det_in, nonvol_parity_det_in, general_det_in};
  wire        gen_clr = wr_gen && !direct_wr && (wdata == `CLR_GENERAL);

  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cell_overvoltage_flags  <= `FAULT_RESET;
      cell_undervoltage_flags <= `FAULT_RESET;
      open_wire_flags         <= `FAULT_RESET;
      general_fault           <= `FAULT_RESET;
    end else begin
      cell_overvoltage_flags  <= next_field(cell_overvoltage_flags, {2'b00, cell_over_det_in}, wr_over,
                                            direct_wr, wdata, `CELL_MASK);
      cell_undervoltage_flags <= next_field(cell_undervoltage_flags, {2'b00, cell_under_det_in}, wr_under,
                                            direct_wr, wdata, `CELL_MASK);
      open_wire_flags         <= next_field(open_wire_flags, {1'b0, open_wire_det_in}, wr_open,
                                            direct_wr, wdata, `OPEN_WIRE_MASK);
      general_fault           <= next_field(general_fault, gen_det, wr_gen || gen_clr, direct_wr,
                                            gen_clr ? `CLR_ALL : wdata, `GENERAL_MASK);
    end
  end

  // ---------------------------------------------------------------
  // Summary register upper fields
  // ---------------------------------------------------------------
  reg  [15:0] summary_flags;
  wire [15:0] sum_det;
  wire [15:0] sum_clr_codes [0:5];
  wire [15:0] sum_clr;
  assign sum_det[8:0]               = 9'h000;
  assign sum_det[`BIT_VSS_OPEN]     = vss_open_det_in;
  assign sum_det[`BIT_CHECKSUM]     = 1'b0;
  assign sum_det[`BIT_REFERENCE]    = reference_det_in;
  assign sum_det[`BIT_REGULATOR]    = regulator_det_in;
  assign sum_det[`BIT_TEMP_MUX]     = temp_mux_det_in;
  assign sum_det[`BIT_CELL_MUX]     = cell_mux_det_in;
  assign sum_det[`BIT_DIE_TEMP]     = die_temp_det_in;
  assign sum_clr_codes[0] = `CLR_VSS_OPEN;
  assign sum_clr_codes[1] = `CLR_REFERENCE;
  assign sum_clr_codes[2] = `CLR_REGULATOR;
  assign sum_clr_codes[3] = `CLR_TEMP_MUX;
  assign sum_clr_codes[4] = `CLR_CELL_MUX;
  assign sum_clr_codes[5] = `CLR_DIE_TEMP;

  // Each flag clears only on its own code or all ones
  wire [5:0] sum_clr_codes_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sum_clr
      assign sum_clr_codes_hit[gi] = (wdata == sum_clr_codes[gi]) || (wdata == `CLR_ALL);
    end
  endgenerate

  // Checksum position never takes a clear; it follows the general register
  assign sum_clr = {sum_clr_codes_hit[5], sum_clr_codes_hit[4], sum_clr_codes_hit[3], sum_clr_codes_hit[2],
                    sum_clr_codes_hit[1], 1'b0, sum_clr_codes_hit[0], 9'h000};

  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      summary_flags <= `FAULT_RESET;
    end else if (wr_sum && direct_wr) begin
      summary_flags <= ((wdata & `SUMMARY_WR_MASK) | sum_det);
    end else if (wr_sum) begin
      summary_flags <= ((summary_flags & ~sum_clr) | sum_det) & `SUMMARY_WR_MASK;
    end else begin
      summary_flags <= (summary_flags | sum_det) & `SUMMARY_WR_MASK;
    end
  end

  wire checksum_error = general_fault[`BIT_NONVOL_PARITY] | general_fault[`BIT_PAGE_ONE_PARITY];
  wire [15:0] fault_summary = summary_flags | ({15'h0000, checksum_error} << `BIT_CHECKSUM);

  // ---------------------------------------------------------------
  // Interrupt status (write one to clear) and mask
  // ---------------------------------------------------------------
  // Status bits catch the rise of each register-nonzero term; the
  // output uses the next status and mask so it agrees with them.
  reg  [`IRQ_WIDTH-1:0] irq_status;
  reg  [`IRQ_WIDTH-1:0] irq_mask;
  reg  [`IRQ_WIDTH-1:0] prev_any;
  wire [`IRQ_WIDTH-1:0] cur_any = {|general_fault, |open_wire_flags, |cell_undervoltage_flags,
                                   |cell_overvoltage_flags, |fault_summary};
  wire [`IRQ_WIDTH-1:0] irq_event = cur_any & ~prev_any;
  wire [`IRQ_WIDTH-1:0] irq_wclr  = wr_ist ? wdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_status       <= {`IRQ_WIDTH{1'b0}};
      irq_mask         <= {`IRQ_WIDTH{1'b0}};
      prev_any         <= {`IRQ_WIDTH{1'b0}};
      fault_active_out <= 1'b0;
      irq_out          <= 1'b0;
    end else begin
      prev_any         <= cur_any;
      irq_status       <= (irq_status & ~irq_wclr) | irq_event;
      fault_active_out <= |cur_any;
      irq_out          <= |(((irq_status & ~irq_wclr) | irq_event) & (wr_imsk ? wdata[`IRQ_WIDTH-1:0] : irq_mask));
      if (wr_imsk) begin
        irq_mask <= wdata[`IRQ_WIDTH-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // APB response: one wait state in the access phase, pready for one cycle
  // ---------------------------------------------------------------
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (is_idx(paddr_in, `IDX_FAULT_SUMMARY)) begin
      rd_mux = fault_summary;
    end else if (is_idx(paddr_in, `IDX_CELL_OVER)) begin
      rd_mux = cell_overvoltage_flags;
    end else if (is_idx(paddr_in, `IDX_CELL_UNDER)) begin
      rd_mux = cell_undervoltage_flags;
    end else if (is_idx(paddr_in, `IDX_OPEN_WIRE)) begin
      rd_mux = open_wire_flags;
    end else if (is_idx(paddr_in, `IDX_GENERAL_FAULT)) begin
      rd_mux = general_fault;
    end else if (is_idx(paddr_in, `IDX_OVERRIDE_CMD)) begin
      rd_mux = {15'h0000, override_armed};
    end else if (is_idx(paddr_in, `IDX_DETECT_STATUS)) begin
      rd_mux = {11'h000, cur_any};
    end else if (is_idx(paddr_in, `IDX_IRQ_STATUS)) begin
      rd_mux = {11'h000, irq_status};
    end else if (is_idx(paddr_in, `IDX_IRQ_MASK)) begin
      rd_mux = {11'h000, irq_mask};
    end
  end

  always @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (psel_in && penable_in && !pready_out) begin
      pready_out  <= 1'b1;
      pslverr_out <= !mapped;
      prdata_out  <= pwrite_in ? 32'h0000_0000 : {16'h0000, rd_mux};
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

endmodule

// ### verification/fault_status_checker.sv
// Concurrent checks on the ports of the fault flag bank.
// Assumes one clock domain; bound onto fault_status_registers.
`timescale 1ns/100ps
module fault_status_checker (
  input wire        clk_sys_in,
  input wire        arst_n_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire        vss_open_det_in,
  input wire        reference_det_in,
  input wire        regulator_det_in,
  input wire        temp_mux_det_in,
  input wire        cell_mux_det_in,
  input wire        die_temp_det_in,
  input wire [13:0] cell_over_det_in,
  input wire [13:0] cell_under_det_in,
  input wire        page_one_parity_det_in,
  input wire        fault_active_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // ----------------------------------------
  // Bus timing and flag setting
  // ----------------------------------------
  chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("pready longer than one cycle");
  chk_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out) else $error("no answer");
  chk_err_ready: assert property (pslverr_out |-> pready_out && $past(psel_in && penable_in)) else $error("bad pslverr");
  chk_vss_sets: assert property ($rose(vss_open_det_in) |-> ##2 fault_active_out) else $error("vss open");
  chk_parity_sets: assert property (page_one_parity_det_in |=> ##1 fault_active_out) else $error("parity");
  chk_ref_sets: assert property (reference_det_in |-> ##2 fault_active_out) else $error("reference");
  chk_reg_sets: assert property (regulator_det_in |-> ##2 fault_active_out) else $error("regulator");
  chk_mux_sets: assert property (temp_mux_det_in || cell_mux_det_in |-> ##2 fault_active_out) else $error("mux");
  chk_die_sets: assert property (die_temp_det_in |-> ##2 fault_active_out) else $error("die temp");
  chk_cell_sets: assert property (|{cell_over_det_in, cell_under_det_in} |-> ##2 fault_active_out) else $error("cell");
  chk_flags_stick: assert property (fault_active_out && !(psel_in && penable_in && pwrite_in) |=> fault_active_out)
    else $error("flag lost without write");
  cov_error: cover property (pslverr_out);
  cov_clear: cover property ($fell(fault_active_out));
  cov_write: cover property (pready_out && pwrite_in);
endmodule

// ### verification/apb_host_model.sv
// Host controller model issuing register reads and writes over APB.
// Assumes the slave shares clk_sys_in and answers through pready_in.
`timescale 1ns/100ps
`include "fault_status_consts.vh"
module apb_host_model (
  input  wire        clk_sys_in,
  output reg         psel_out,
  output reg         penable_out,
  output reg         pwrite_out,
  output reg  [11:0] paddr_out,
  output reg  [31:0] pwdata_out,
  output wire [3:0]  pstrb_out,
  input  wire [31:0] prdata_in,
  input  wire        pready_in,
  input  wire        pslverr_in
);
  assign pstrb_out = 4'hf;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0000_0000;
  end
  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  task xfer(input w, input [8:0] idx, input [15:0] d, output [15:0] q, output e);
    @(posedge clk_sys_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= {1'b0, idx, 2'b00};
    pwdata_out <= {16'h0000, d};
    @(posedge clk_sys_in);
    penable_out <= 1'b1;
    do @(posedge clk_sys_in); while (pready_in !== 1'b1);
    q = prdata_in[15:0];
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~paddr_out;
    pwdata_out <= ~pwdata_out;
  endtask
  task direct(input [8:0] idx, input [15:0] d);
    reg [15:0] q;
    reg        e;
    xfer(1'b1, `IDX_OVERRIDE_CMD, 16'h0001, q, e);
    xfer(1'b1, idx, d, q, e);
  endtask
endmodule

// ### verification/fault_status_registers_bench.sv
// Self-checking bench for the fault flag bank, driven through the APB host model.
// Assumes the design header is on the include path.
`timescale 1ns/100ps
`include "fault_status_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module fault_status_registers_bench;
  reg         clk_sys_in, arst_n_in, nv_det, p1_det, e;
  reg  [5:0]  sdet;
  reg  [14:0] cdet;
  reg  [1:0]  csel;
  reg  [15:0] q;
  wire        psel, penable, pwrite, pready, pslverr, fault_active, irq;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0]  pstrb;
  wire [95:0] codes = {`CLR_DIE_TEMP, `CLR_CELL_MUX, `CLR_TEMP_MUX, `CLR_REGULATOR, `CLR_REFERENCE, `CLR_VSS_OPEN};
  wire [26:0] cidx  = {`IDX_OPEN_WIRE, `IDX_CELL_UNDER, `IDX_CELL_OVER};
  wire [47:0] cmask = {`OPEN_WIRE_MASK, `CELL_MASK, `CELL_MASK};
  integer     error_cnt = 0, tests_run = 0, i;
  apb_host_model u_host (.clk_sys_in(clk_sys_in), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr));
  fault_status_registers u_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .vss_open_det_in(sdet[0]),
    .reference_det_in(sdet[1]), .regulator_det_in(sdet[2]), .temp_mux_det_in(sdet[3]), .cell_mux_det_in(sdet[4]),
    .die_temp_det_in(sdet[5]), .cell_over_det_in(csel == 2'd0 ? cdet[13:0] : 14'h0000),
    .cell_under_det_in(csel == 2'd1 ? cdet[13:0] : 14'h0000), .open_wire_det_in(csel == 2'd2 ? cdet : 15'h0000),
    .general_det_in(2'b00), .nonvol_parity_det_in(nv_det), .page_one_parity_det_in(p1_det),
    .fault_active_out(fault_active), .irq_out(irq));
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #40000;
    error_cnt++;
    wrap_up;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task wrap_up;
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task wr(input [8:0] idx, input [15:0] d);
    u_host.xfer(1'b1, idx, d, q, e);
  endtask
  task rd_chk(input [8:0] idx, input [15:0] exp);
    u_host.xfer(1'b0, idx, 16'h0000, q, e);
    `CHK(q, exp)
  endtask
  task pulse(input [5:0] s, input [1:0] p, input [14:0] c);
    @(posedge clk_sys_in);
    sdet <= s;
    {nv_det, p1_det} <= p;
    cdet <= c;
    @(posedge clk_sys_in);
    sdet <= 6'h00;
    {nv_det, p1_det} <= 2'b00;
    cdet <= 15'h0000;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    arst_n_in = 1'b0;
    {nv_det, p1_det, sdet, cdet, csel} = 25'h0;
    tick(8);
    arst_n_in <= 1'b1;
    tick(3);
    for (i = 0; i < 3; i++) rd_chk(cidx[i*9 +: 9], `FAULT_RESET);
    u_host.xfer(1'b0, 9'h0a0, 16'h0000, q, e);
    `CHK(e, 1'b1)
    for (i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 2'b00, 15'h0000);
      tick(2);
      `CHK(fault_active, 1'b1)
      rd_chk(`IDX_FAULT_SUMMARY, codes[i*16 +: 16]);
      wr(`IDX_FAULT_SUMMARY, codes[((i + 1) % 6)*16 +: 16]);
      rd_chk(`IDX_FAULT_SUMMARY, codes[i*16 +: 16]);
      wr(`IDX_FAULT_SUMMARY, (i % 2) ? `CLR_ALL : codes[i*16 +: 16]);
      rd_chk(`IDX_FAULT_SUMMARY, 16'h0000);
    end
    for (i = 0; i < 2; i++) begin
      pulse(6'h00, 2'b01 << i, 15'h0000);
      rd_chk(`IDX_FAULT_SUMMARY, 16'h0400);
      wr(`IDX_FAULT_SUMMARY, `CLR_ALL);
      rd_chk(`IDX_FAULT_SUMMARY, 16'h0400);
      wr(`IDX_GENERAL_FAULT, `CLR_GENERAL);
      rd_chk(`IDX_FAULT_SUMMARY, 16'h0000);
    end
    for (i = 0; i < 3; i++) begin
      csel <= i[1:0];
      pulse(6'h00, 2'b00, 15'h2001);
      rd_chk(cidx[i*9 +: 9], 16'h2001);
      wr(cidx[i*9 +: 9], 16'h1234);
      rd_chk(cidx[i*9 +: 9], 16'h2001);
      cdet <= 15'h0001;
      wr(cidx[i*9 +: 9], `CLR_ALL);
      rd_chk(cidx[i*9 +: 9], 16'h0001);
      cdet <= 15'h0000;
      wr(cidx[i*9 +: 9], `CLR_ALL);
      rd_chk(cidx[i*9 +: 9], 16'h0000);
      u_host.direct(cidx[i*9 +: 9], `CLR_ALL);
      rd_chk(cidx[i*9 +: 9], cmask[i*16 +: 16]);
      u_host.direct(cidx[i*9 +: 9], 16'h0000);
      rd_chk(cidx[i*9 +: 9], 16'h0000);
    end
    u_host.direct(`IDX_FAULT_SUMMARY, `CLR_ALL);
    rd_chk(`IDX_FAULT_SUMMARY, `SUMMARY_WR_MASK);
    u_host.direct(`IDX_FAULT_SUMMARY, 16'h0000);
    rd_chk(`IDX_FAULT_SUMMARY, 16'h0000);
    tick(2);
    `CHK(fault_active, 1'b0)
    wr(`IDX_IRQ_MASK, 16'h0000);
    wr(`IDX_IRQ_STATUS, 16'h001f);
    csel <= 2'd0;
    pulse(6'h00, 2'b00, 15'h0004);
    tick(2);
    `CHK(irq, 1'b0)
    rd_chk(`IDX_IRQ_STATUS, 16'h0002);
    wr(`IDX_IRQ_MASK, 16'h0002);
    tick(2);
    `CHK(irq, 1'b1)
    wr(`IDX_IRQ_STATUS, 16'h0002);
    tick(2);
    `CHK(irq, 1'b0)
    rd_chk(`IDX_IRQ_STATUS, 16'h0000);
    wrap_up;
  end
endmodule
bind fault_status_registers fault_status_checker u_chk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .vss_open_det_in(vss_open_det_in), .reference_det_in(reference_det_in),
  .regulator_det_in(regulator_det_in), .temp_mux_det_in(temp_mux_det_in), .cell_mux_det_in(cell_mux_det_in),
  .die_temp_det_in(die_temp_det_in), .cell_over_det_in(cell_over_det_in), .cell_under_det_in(cell_under_det_in),
  .page_one_parity_det_in(page_one_parity_det_in), .fault_active_out(fault_active_out));
